/* File: rtl/cct_cfg.svh */
// Purpose: Named constants for the counter compare table block
// Assumes: APB with 32-bit data, table words of 16 bits
// Notes:   Offsets are byte addresses
`ifndef CCT_CFG_SVH
`define CCT_CFG_SVH

// Register offsets
`define CCT_OFF_CMD        12'h000
`define CCT_OFF_INIT       12'h004
`define CCT_OFF_STATUS     12'h008
`define CCT_OFF_LAST_TASK  12'h00C
`define CCT_OFF_TABLE      12'h100
`define CCT_OFF_TABLE_END  12'h174

// Sizes
`define CCT_NUM_PORTS      6
`define CCT_MAX_PORT       16'h0005
`define CCT_NUM_WORDS      30
`define CCT_NUM_ENTRIES    6
`define CCT_NUM_TASKS      16
`define CCT_MAX_TARGETS    16'h0006

// Control codes
`define CCT_CODE_TGT_RUN   16'h0000
`define CCT_CODE_RNG_RUN   16'h0001
`define CCT_CODE_TGT_LOAD  16'h0002
`define CCT_CODE_RNG_LOAD  16'h0003

// Task word codes
`define CCT_TASK_DISABLED  16'hFFFF
`define CCT_TASK_SILENT    16'hAAAA
`define CCT_DIR_BIT        15

// Init register bits
`define CCT_INIT_START     0
`define CCT_INIT_STOP      1

// Status register bits
`define CCT_ST_ERROR       0
`define CCT_ST_ACTIVE      1
`define CCT_ST_RANGE       2
`define CCT_ST_VALID       3
`define CCT_ST_FATAL       4
`define CCT_ST_INRNG_LSB   8
`define CCT_ST_PORT_LSB    16

// Reset values
`define CCT_RST_WORD       16'h0000
`define CCT_RST_DATA       32'h0000_0000

`endif

/* File: rtl/cct_pkg.sv */
// Purpose: Types shared by the counter compare table block
// Assumes: Constants come from cct_cfg.svh
// Notes:   Types only
package cct_pkg;

  typedef enum logic {
    cct_method_target,
    cct_method_range
  } cct_method_e;

  typedef logic [15:0] cct_word_t;
  typedef logic [31:0] cct_val_t;
  typedef logic [2:0]  cct_port_t;

endpackage

/* File: rtl/cct_compare_table.sv */
// Purpose: Comparison table unit for high-speed counter present values
// Assumes: Counter state inputs synchronous to clk, APB master per AMBA
// Notes:   Zero wait state APB, one call issued per cycle at most
// Notes on behaviour
// R1 - Issuer picks the counter with port code 0 to 5; counter 5 may be absent.
// R2 - Code 0 stores a target table and starts comparing at once.
// R3 - Code 1 stores a range table and starts range comparison at once.
// R4 - Codes 2 and 3 only store the table; a later init start begins.
// R5 - Target table spans 4 to 19 words; first word counts up to 6 targets.
// R6 - Range table always holds six ranges in 30 words.
// R7 - A range with task FFFF is disabled and never compared.
// R8 - Error on bad port or code, or target count zero or above 6.
// R9 - Error when any range upper limit is below its lower limit.
// R10 - Error when every range of a range table is disabled.
// R11 - Error when increment-only counter has a table entry counting down.
// R12 - Error on duplicate target with same direction in increment-only linear mode.
// R13 - Error on value above ring maximum in ring mode, or port not a counter.
// R14 - Error when a different method is issued while comparison runs.
// R15 - Table stays until replaced or run mode ends; each command restarts.
// R16 - Only the init stop command stops comparison, whatever started it; the code also stops it on codes 2 and 3, on run mode end and on fatal error.
// R17 - Every target checked; equality calls the linked task; tasks may be shared.
// R18 - Task word bit 15 clear compares counting up, set counting down.
// R19 - Target reached in disabled direction does not match after reversal.
// R20 - Range task called once per entry; lowest index first, others later.
// R21 - Task AAAA raises no call but still shows in-range results.
// R22 - Unregistered task accepted at load; fatal error on first matching call.
// R23 - Compare on every present value change so no equality is missed.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "cct_cfg.svh"

module cct_compare_table
  import cct_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Counter side
  input  wire logic [5:0][31:0]     cnt_pv,
  input  wire logic [5:0]           cnt_is_counter,
  input  wire logic [5:0]           cnt_incr_only,
  input  wire logic [5:0]           cnt_ring_mode,
  input  wire logic [5:0][31:0]     cnt_ring_max,
  input  wire logic                 run_mode,
  // Task side
  input  wire logic [15:0]          task_registered,
  output logic                      task_call,
  output logic [14:0]               task_num,
  output logic                      fatal_error,
  output logic                      instruction_error_flag,
  output logic [5:0]                range_in_progress,
  output logic                      comparing
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic cct_val_t tbl_val(input cct_word_t t [`CCT_NUM_WORDS],
                                       input int idx);
    tbl_val = {t[idx+1], t[idx]};
  endfunction

  // Linear mode values are signed, ring mode values unsigned
  function automatic logic val_lt(input cct_val_t a, input cct_val_t b,
                                  input logic ring);
    val_lt = ring ? (a < b) : ($signed(a) < $signed(b));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  cct_word_t   stage_ff [`CCT_NUM_WORDS];
  cct_word_t   live_ff  [`CCT_NUM_WORDS];
  cct_word_t   nxt_stage [`CCT_NUM_WORDS];
  cct_word_t   nxt_live  [`CCT_NUM_WORDS];
  cct_method_e method_ff, nxt_method;
  cct_port_t   port_ff, nxt_port;
  logic [2:0]  count_ff, nxt_count;
  logic        valid_ff, nxt_valid;
  logic        active_ff, nxt_active;
  logic        error_ff, nxt_error;
  logic        fatal_ff, nxt_fatal;
  cct_val_t    prev_pv_ff, nxt_prev_pv;
  logic [5:0]  in_rng_ff, nxt_in_rng;
  logic [5:0]  pend_ff, nxt_pend;
  logic        call_ff, nxt_call;
  logic [14:0] task_ff, nxt_task;
  logic        pready_ff, nxt_pready;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pslverr_ff, nxt_pslverr;
  cct_word_t   last_cmd_ff, nxt_last_cmd;

  // Decode
  logic        acc_wr;
  logic        is_cmd, is_init, is_status, is_last, is_table;
  logic [4:0]  tbl_idx;
  cct_word_t   cmd_port, cmd_code;
  cct_port_t   cmd_p;
  logic        cmd_err;
  logic        cmd_range;
  logic [2:0]  cmd_cnt;
  cct_val_t    pv_now;
  logic        pv_moved, pv_up;
  logic [5:0]  hit;
  logic        serve;
  int          serve_idx;
  cct_word_t   serve_word;

  ////////////////////////////////////////////////////////////////////////////
  // Table check on command write

  always_comb begin
    cct_val_t v;
    cct_val_t w;
    logic     all_off;
    logic     ring;
    logic     inc;
    cmd_port  = pwdata[31:16];
    cmd_code  = pwdata[15:0];
    cmd_p     = cmd_port[2:0];
    cmd_range = cmd_code[0];
    cmd_cnt   = stage_ff[0][2:0];
    cmd_err   = 1'b0;
    all_off   = 1'b1;
    v         = `CCT_RST_DATA;
    w         = `CCT_RST_DATA;
    ring      = 1'b0;
    inc       = 1'b0;
    if (cmd_port > `CCT_MAX_PORT || cmd_code > `CCT_CODE_RNG_LOAD) begin
      cmd_err = 1'b1; // see R8
    end else begin
      ring = cnt_ring_mode[cmd_p];
      inc  = cnt_incr_only[cmd_p];
      if (!cnt_is_counter[cmd_p])
        cmd_err = 1'b1; // see R13
      if (active_ff && (method_ff == cct_method_range) != cmd_range)
        cmd_err = 1'b1; // see R14
      if (!cmd_range) begin
        // Target table: count word, then value low, value high, task
        if (stage_ff[0] == `CCT_RST_WORD || stage_ff[0] > `CCT_MAX_TARGETS)
          cmd_err = 1'b1; // see R5 R8
        for (int k = 0; k < `CCT_NUM_ENTRIES; k++) begin
          if (k < int'(cmd_cnt) && !cmd_err) begin
            v = tbl_val(stage_ff, 1 + 3 * k);
            if (inc && stage_ff[3 + 3 * k][`CCT_DIR_BIT])
              cmd_err = 1'b1; // see R11
            if (ring && v > cnt_ring_max[cmd_p])
              cmd_err = 1'b1; // see R13
            for (int j = 0; j < k; j++) begin
              w = tbl_val(stage_ff, 1 + 3 * j);
              if (inc && !ring && v == w &&
                  stage_ff[3 + 3 * k][`CCT_DIR_BIT] ==
                  stage_ff[3 + 3 * j][`CCT_DIR_BIT])
                cmd_err = 1'b1; // see R12
            end
          end
        end
      end else begin
        // Range table: six ranges of five words each
        for (int k = 0; k < `CCT_NUM_ENTRIES; k++) begin
          if (stage_ff[5 * k + 4] != `CCT_TASK_DISABLED) begin // see R7 R6
            all_off = 1'b0;
            v = tbl_val(stage_ff, 5 * k);
            w = tbl_val(stage_ff, 5 * k + 2);
            if (val_lt(w, v, ring))
              cmd_err = 1'b1; // see R9
            if (ring && (v > cnt_ring_max[cmd_p] || w > cnt_ring_max[cmd_p]))
              cmd_err = 1'b1; // see R13
          end
        end
        if (all_off)
          cmd_err = 1'b1; // see R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison

  always_comb begin
    cct_val_t lo;
    cct_val_t hi;
    logic     ring;
    ring     = cnt_ring_mode[port_ff];
    pv_now   = cnt_pv[port_ff];
    pv_moved = pv_now != prev_pv_ff; // see R23
    // Ring wraps count in the direction of the step, not of the values
    pv_up    = (ring && prev_pv_ff == cnt_ring_max[port_ff] && pv_now == `CCT_RST_DATA) ||
               (val_lt(prev_pv_ff, pv_now, ring) &&
                !(ring && prev_pv_ff == `CCT_RST_DATA && pv_now == cnt_ring_max[port_ff]));
    hit        = 6'h00;
    nxt_in_rng = 6'h00;
    lo         = `CCT_RST_DATA;
    hi         = `CCT_RST_DATA;
    for (int k = 0; k < `CCT_NUM_ENTRIES; k++) begin
      if (method_ff == cct_method_target) begin
        // Only an arrival in the enabled direction counts
        if (active_ff && k < int'(count_ff) && pv_moved &&
            pv_now == tbl_val(live_ff, 1 + 3 * k) &&
            live_ff[3 + 3 * k][`CCT_DIR_BIT] == !pv_up)
          hit[k] = 1'b1; // see R17 R18 R19
      end else begin
        lo = tbl_val(live_ff, 5 * k);
        hi = tbl_val(live_ff, 5 * k + 2);
        if (active_ff && live_ff[5 * k + 4] != `CCT_TASK_DISABLED &&
            !val_lt(pv_now, lo, ring) && !val_lt(hi, pv_now, ring))
          nxt_in_rng[k] = 1'b1; // see R7 R21
        hit[k] = nxt_in_rng[k] && !in_rng_ff[k]; // see R20
      end
    end
    // Lowest index served first
    serve_idx = 0;
    serve     = 1'b0;
    for (int k = `CCT_NUM_ENTRIES - 1; k >= 0; k--) begin
      if (pend_ff[k]) begin
        serve_idx = k;
        serve     = 1'b1; // see R20
      end
    end
    serve_word = (method_ff == cct_method_target) ? live_ff[3 + 3 * serve_idx]
                                                   : live_ff[5 * serve_idx + 4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic start;
    logic stop;
    start        = 1'b0;
    stop         = 1'b0;
    acc_wr       = psel && penable && pready_ff && pwrite;
    is_cmd       = paddr == `CCT_OFF_CMD;
    is_init      = paddr == `CCT_OFF_INIT;
    is_status    = paddr == `CCT_OFF_STATUS;
    is_last      = paddr == `CCT_OFF_LAST_TASK;
    is_table     = paddr >= `CCT_OFF_TABLE && paddr <= `CCT_OFF_TABLE_END &&
                   paddr[1:0] == 2'b00;
    tbl_idx      = 5'(paddr[11:2] - 10'(`CCT_OFF_TABLE >> 2));
    nxt_stage    = stage_ff;
    nxt_live     = live_ff;
    nxt_method   = method_ff;
    nxt_port     = port_ff;
    nxt_count    = count_ff;
    nxt_valid    = valid_ff;
    nxt_active   = active_ff;
    nxt_error    = error_ff;
    nxt_fatal    = fatal_ff;
    nxt_prev_pv  = pv_now;
    nxt_pend     = pend_ff;
    nxt_call     = 1'b0;
    nxt_task     = task_ff;
    nxt_last_cmd = last_cmd_ff;

    // Register writes
    if (acc_wr && is_table)
      nxt_stage[tbl_idx] = pwdata[15:0];
    if (acc_wr && is_cmd) begin
      nxt_last_cmd = pwdata[15:0];
      nxt_error    = cmd_err; // see R8
      if (!cmd_err) begin
        nxt_live   = stage_ff; // see R15
        nxt_port   = cmd_p;
        nxt_method = cmd_range ? cct_method_range : cct_method_target;
        nxt_count  = cmd_range ? 3'(`CCT_NUM_ENTRIES) : cmd_cnt;
        nxt_valid  = 1'b1;
        nxt_active = 1'b0; // see R4
        start      = !cmd_code[1]; // see R2 R3
      end
    end
    if (acc_wr && is_init) begin
      stop  = pwdata[`CCT_INIT_STOP]; // see R16
      start = pwdata[`CCT_INIT_START] && !stop && valid_ff; // see R4
    end
    if (start) begin
      nxt_active  = 1'b1;
      nxt_pend    = 6'h00;
      nxt_prev_pv = cnt_pv[nxt_port];
    end else if (stop) begin
      nxt_active = 1'b0;
      nxt_pend   = 6'h00;
    end else if (active_ff) begin
      // New hits win over the one being served
      if (serve) begin
        nxt_pend[serve_idx] = 1'b0;
        if (serve_word != `CCT_TASK_SILENT) begin // see R21
          nxt_task = serve_word[14:0];
          if (serve_word[14:0] >= 15'(`CCT_NUM_TASKS) ||
              !task_registered[serve_word[3:0]]) begin
            nxt_fatal  = 1'b1; // see R22
            nxt_active = 1'b0;
          end else begin
            nxt_call = 1'b1; // see R17
          end
        end
      end
      nxt_pend = nxt_pend | hit;
    end
    if (!run_mode) begin
      nxt_valid  = 1'b0; // see R15
      nxt_active = 1'b0;
      nxt_pend   = 6'h00;
    end

    // APB answer, zero wait states
    nxt_pready  = psel && !penable;
    nxt_pslverr = psel && !penable &&
                  !(is_cmd || is_init || is_status || is_last || is_table);
    nxt_prdata  = `CCT_RST_DATA;
    if (psel && !penable && !pwrite) begin
      if (is_cmd)
        nxt_prdata = {16'h0000, last_cmd_ff};
      else if (is_status) begin
        nxt_prdata[`CCT_ST_ERROR]          = error_ff;
        nxt_prdata[`CCT_ST_ACTIVE]         = active_ff;
        nxt_prdata[`CCT_ST_RANGE]          = method_ff == cct_method_range;
        nxt_prdata[`CCT_ST_VALID]          = valid_ff;
        nxt_prdata[`CCT_ST_FATAL]          = fatal_ff;
        nxt_prdata[`CCT_ST_INRNG_LSB +: 6] = in_rng_ff;
        nxt_prdata[`CCT_ST_PORT_LSB +: 3]  = port_ff;
      end else if (is_last)
        nxt_prdata = {17'h00000, task_ff};
      else if (is_table)
        nxt_prdata = {16'h0000, stage_ff[tbl_idx]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `CCT_NUM_WORDS; i++) begin
        stage_ff[i] <= `CCT_RST_WORD;
        live_ff[i]  <= `CCT_RST_WORD;
      end
      method_ff   <= cct_method_target;
      port_ff     <= 3'h0;
      count_ff    <= 3'h0;
      valid_ff    <= 1'b0;
      active_ff   <= 1'b0;
      error_ff    <= 1'b0;
      fatal_ff    <= 1'b0;
      prev_pv_ff  <= `CCT_RST_DATA;
      in_rng_ff   <= 6'h00;
      pend_ff     <= 6'h00;
      call_ff     <= 1'b0;
      task_ff     <= 15'h0000;
      pready_ff   <= 1'b0;
      prdata_ff   <= `CCT_RST_DATA;
      pslverr_ff  <= 1'b0;
      last_cmd_ff <= `CCT_RST_WORD;
    end else begin
      stage_ff    <= nxt_stage;
      live_ff     <= nxt_live;
      method_ff   <= nxt_method;
      port_ff     <= nxt_port;
      count_ff    <= nxt_count;
      valid_ff    <= nxt_valid;
      active_ff   <= nxt_active;
      error_ff    <= nxt_error;
      fatal_ff    <= nxt_fatal;
      prev_pv_ff  <= nxt_prev_pv;
      in_rng_ff   <= nxt_in_rng;
      pend_ff     <= nxt_pend;
      call_ff     <= nxt_call;
      task_ff     <= nxt_task;
      pready_ff   <= nxt_pready;
      prdata_ff   <= nxt_prdata;
      pslverr_ff  <= nxt_pslverr;
      last_cmd_ff <= nxt_last_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pready                 = pready_ff;
  assign prdata                 = prdata_ff;
  assign pslverr                = pslverr_ff;
  assign task_call              = call_ff;
  assign task_num               = task_ff;
  assign fatal_error            = fatal_ff;
  assign instruction_error_flag = error_ff;
  assign range_in_progress      = in_rng_ff;
  assign comparing              = active_ff;

endmodule // cct_compare_table

/* File: testbench/cct_compare_table_sva.sv */
// Purpose: Port assertions for the compare table block
// Assumes: Single clock domain, arst_n active low
// Notes:   Attached by the bind at the foot of this file
`timescale 1ns/1ps
`include "cct_cfg.svh"

module cct_compare_table_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Control and task side
  input wire logic        run_mode,
  input wire logic        task_call,
  input wire logic        fatal_error,
  input wire logic        instruction_error_flag,
  input wire logic        comparing
);
  logic wr_any;
  logic wr_cmd;
  logic wr_init;

  assign wr_any  = psel && penable && pready && pwrite;
  assign wr_cmd  = wr_any && (paddr == `CCT_OFF_CMD);
  assign wr_init = wr_any && (paddr == `CCT_OFF_INIT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; psel && penable && pready; endsequence

  ////////////////////////////////////////////////////////////////////////////
  property p_apb_answer; s_setup |=> s_answer; endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("no answer after setup");
  property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused read returned data");
  property p_cmd_start; wr_cmd && pwdata[15:1] == 15'h0000 |=> ##1 (comparing || instruction_error_flag); endproperty
  a_cmd_start: assert property (p_cmd_start)
    else $error("run command did not start comparison");
  property p_load_only; wr_cmd && pwdata[15:1] == 15'h0001 |=> ##1 (!comparing || instruction_error_flag); endproperty
  a_load_only: assert property (p_load_only)
    else $error("load command started comparison");
  property p_start_cause; $rose(comparing) |-> $past(wr_any) || $past(wr_any, 2); endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("comparison started without a write");
  property p_init_stop; wr_init && pwdata[1] |=> ##1 !comparing; endproperty
  a_init_stop: assert property (p_init_stop)
    else $error("stop did not end comparison");
  property p_run_stop; !run_mode |=> ##1 !comparing; endproperty
  a_run_stop: assert property (p_run_stop)
    else $error("comparison kept outside run mode");
  property p_err_cause; $changed(instruction_error_flag) |-> $past(wr_cmd) || $past(wr_cmd, 2); endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("error flag moved without a command");
  property p_call_active; task_call |-> $past(comparing); endproperty
  a_call_active: assert property (p_call_active)
    else $error("call while not comparing");
  property p_fatal_hold; fatal_error |=> fatal_error; endproperty
  a_fatal_hold: assert property (p_fatal_hold)
    else $error("fatal error cleared");
  property p_fatal_quiet; $rose(fatal_error) |-> !task_call ##[0:1] !comparing; endproperty
  a_fatal_quiet: assert property (p_fatal_quiet)
    else $error("fatal error with call or comparison");
endmodule // cct_compare_table_chk

bind cct_compare_table cct_compare_table_chk i_chk (
  .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
  .run_mode, .task_call, .fatal_error, .instruction_error_flag, .comparing
);

/* File: testbench/cct_counter_model.sv */
// Purpose: Counter present-value model facing the compare table
// Assumes: All six counters share one value
// Notes:   One count per clock, so every value on the way is seen
`timescale 1ns/1ps

module cct_counter_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Goal set by the bench
  input  wire logic [31:0] goal,
  // Present values
  output logic [5:0][31:0] cnt_pv
);
  logic [31:0] pv_ff;
  logic [31:0] nxt_pv;

  always_comb begin
    nxt_pv = pv_ff;
    if (goal > pv_ff) begin
      nxt_pv = pv_ff + 32'h0000_0001;
    end else if (goal < pv_ff) begin
      nxt_pv = pv_ff - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pv_ff <= 32'h0000_0000;
    end else begin
      pv_ff <= nxt_pv;
    end
  end

  assign cnt_pv = {6{pv_ff}};
endmodule // cct_counter_model

/* File: testbench/testbench.sv */
// Purpose: Directed bench for the compare table block
// Assumes: Zero wait APB, counter model steps one per clock
// Notes:   Fatal case runs last, the flag is sticky
`timescale 1ns/1ps
`include "cct_cfg.svh"
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end

module testbench;
  import cct_pkg::*;
  logic             clk, arst_n, psel, penable, pwrite, pready, pslverr, run_mode, rd_err;
  logic             task_call, fatal_error, instruction_error_flag, comparing;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, goal, rd_data;
  logic [5:0][31:0] cnt_pv, cnt_ring_max;
  logic [5:0]       cnt_is_counter, cnt_incr_only, cnt_ring_mode, range_in_progress;
  logic [15:0]      task_registered;
  logic [14:0]      task_num;
  logic [14:0]      calls[$];
  int               err_count, comparisons;

  cct_compare_table i_dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .cnt_pv, .cnt_is_counter, .cnt_incr_only, .cnt_ring_mode, .cnt_ring_max,
    .run_mode, .task_registered, .task_call, .task_num, .fatal_error, .comparing,
    .instruction_error_flag, .range_in_progress);
  cct_counter_model i_model (.clk, .arst_n, .goal, .cnt_pv);

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (task_call === 1'h1) calls.push_back(task_num);

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin @(posedge clk); n++; end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin err_count++; tally_and_finish(); end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic tw(input int i, input logic [15:0] v);
    apb(1'h1, 12'(`CCT_OFF_TABLE + 4 * i), {16'h0000, v});
  endtask
  task automatic tgt(input int k, input logic [31:0] v, input logic [15:0] t);
    tw(1 + 3 * k, v[15:0]); tw(2 + 3 * k, v[31:16]); tw(3 + 3 * k, t);
  endtask
  task automatic rng(input int k, input logic [15:0] lo, hi, t);
    tw(5 * k, lo); tw(5 * k + 1, 16'h0000); tw(5 * k + 2, hi); tw(5 * k + 3, 16'h0000);
    tw(5 * k + 4, t);
  endtask
  task automatic cmd(input logic [15:0] p, input logic [15:0] c, input logic e);
    apb(1'h1, `CCT_OFF_CMD, {p, c});
    repeat (2) @(posedge clk);
    `CHK("error_flag", e, instruction_error_flag)
  endtask
  task automatic init(input logic [31:0] d);
    apb(1'h1, `CCT_OFF_INIT, d);
    repeat (2) @(posedge clk);
  endtask
  task automatic go(input logic [31:0] g);
    int n;
    n = 0;
    goal <= g;
    do begin @(posedge clk); n++; end while (cnt_pv[0] !== g && n < 500);
    if (n >= 500) begin err_count++; tally_and_finish(); end
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK("outputs", 25'h0, {task_call, task_num, fatal_error, instruction_error_flag, comparing, range_in_progress})
    apb(1'h0, `CCT_OFF_STATUS, 32'h0); `CHK("status", 32'h0, rd_data)
    apb(1'h0, 12'h010, 32'h0); `CHK("unmapped", 33'h1_0000_0000, {rd_err, rd_data})
    tw(29, 16'hBEEF);
    apb(1'h0, `CCT_OFF_TABLE_END, 32'h0); `CHK("table_word", 16'hBEEF, rd_data[15:0])
    init(32'h1); `CHK("start_no_table", 1'h0, comparing)
  endtask
  task automatic t_errors();
    tw(0, 16'h0001); tgt(0, 32'h64, 16'h0001);
    cmd(16'h0006, 16'h0002, 1'h1);
    cmd(16'h0000, 16'h0004, 1'h1);
    cmd(16'h0005, 16'h0002, 1'h0);
    tw(0, 16'h0000); cmd(16'h0000, 16'h0002, 1'h1);
    tw(0, 16'h0007); cmd(16'h0000, 16'h0002, 1'h1);
    tw(0, 16'h0006); cmd(16'h0000, 16'h0002, 1'h0);
    tw(0, 16'h0001); cnt_incr_only <= 6'h01; tgt(0, 32'h64, 16'h8001);
    cmd(16'h0000, 16'h0002, 1'h1);
    tw(0, 16'h0002); tgt(0, 32'h64, 16'h0001); tgt(1, 32'h64, 16'h0002);
    cmd(16'h0000, 16'h0002, 1'h1);
    cnt_incr_only <= 6'h00; cmd(16'h0000, 16'h0002, 1'h0);
    tw(0, 16'h0001); cnt_ring_mode <= 6'h01; cnt_ring_max[0] <= 32'h32;
    cmd(16'h0000, 16'h0002, 1'h1);
    cnt_ring_max[0] <= 32'hC8; cmd(16'h0000, 16'h0002, 1'h0);
    cnt_ring_mode <= 6'h00; cnt_is_counter <= 6'h3E;
    cmd(16'h0000, 16'h0002, 1'h1);
    cnt_is_counter <= 6'h3F; rng(0, 16'h14, 16'h0A, 16'h0005);
    for (int k = 1; k < 6; k++) rng(k, 16'h0000, 16'h0000, `CCT_TASK_DISABLED);
    cmd(16'h0000, 16'h0003, 1'h1);
    rng(0, 16'h0A, 16'h14, `CCT_TASK_DISABLED); cmd(16'h0000, 16'h0003, 1'h1);
    rng(0, 16'h0A, 16'h14, 16'h0005); cmd(16'h0000, 16'h0001, 1'h0);
    tw(0, 16'h0001); tgt(0, 32'h64, 16'h0001); cmd(16'h0000, 16'h0000, 1'h1);
    `CHK("comparing", 1'h1, comparing)
    init(32'h2);
  endtask
  task automatic t_target();
    tw(0, 16'h0002); tgt(0, 32'h0A, 16'h0003); tgt(1, 32'h05, 16'h8004);
    calls.delete(); cmd(16'h0000, 16'h0000, 1'h0);
    `CHK("comparing", 1'h1, comparing)
    go(32'h14); go(32'h00); go(32'h05); go(32'h03);
    `CHK("call_count", 2, calls.size())
    `CHK("first_call", 15'h3, calls[0])
    `CHK("second_call", 15'h4, calls[1])
    apb(1'h0, `CCT_OFF_LAST_TASK, 32'h0); `CHK("last_task", 32'h4, rd_data)
  endtask
  task automatic t_stop();
    cmd(16'h0000, 16'h0002, 1'h0); `CHK("comparing", 1'h0, comparing)
    init(32'h1); `CHK("comparing", 1'h1, comparing)
    init(32'h3); `CHK("comparing", 1'h0, comparing)
    calls.delete(); go(32'h0A); `CHK("call_count", 0, calls.size())
    run_mode <= 1'h0; repeat (3) @(posedge clk); run_mode <= 1'h1;
    init(32'h1); `CHK("comparing", 1'h0, comparing)
  endtask
  task automatic t_range();
    go(32'h00); rng(0, 16'h1E, 16'h28, 16'h0006); rng(1, 16'h00, 16'h64, `CCT_TASK_DISABLED);
    rng(2, 16'h1E, 16'h32, 16'h0007); rng(3, 16'h1E, 16'h3C, `CCT_TASK_SILENT);
    for (int k = 4; k < 6; k++) rng(k, 16'h0000, 16'h0000, `CCT_TASK_DISABLED);
    calls.delete(); cmd(16'h0000, 16'h0001, 1'h0);
    `CHK("in_range", 6'h00, range_in_progress)
    go(32'h2D); `CHK("call_count", 2, calls.size())
    `CHK("first_call", 15'h6, calls[0])
    `CHK("second_call", 15'h7, calls[1])
    `CHK("in_range", 6'h0C, range_in_progress)
  endtask
  task automatic t_fatal();
    init(32'h2); task_registered <= 16'hFDFF; tw(0, 16'h0001); tgt(0, 32'h32, 16'h0009);
    calls.delete(); cmd(16'h0000, 16'h0000, 1'h0);
    go(32'h3C); `CHK("fatal", 1'h1, fatal_error)
    `CHK("call_count", 0, calls.size())
    `CHK("comparing", 1'h0, comparing)
  endtask

  initial begin
    arst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h000;
    pwdata = 32'h0; goal = 32'h0; run_mode = 1'h1; cnt_is_counter = 6'h3F;
    cnt_incr_only = 6'h00; cnt_ring_mode = 6'h00; cnt_ring_max = '0;
    task_registered = 16'hFFFF; err_count = 0; comparisons = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    t_reset(); t_errors(); t_target(); t_stop(); t_range(); t_fatal();
    tally_and_finish();
  end
endmodule // testbench
